// file: src/sbcm_core.sv
// Control core: serial word port, mode machine, watchdog, fault latches.
// Assumes all pins asynchronous to clk_sys; analog monitors as levels.
//
// Notes on behaviour
// - Supply over/under voltage sets flag, interrupts
// - Supply flags held until read and fault gone
// - Wake bits live, first read shows source
// - Switches a and b: bit AND pwm pin
// - Over-temperature latches switch off until rewritten
// - Reset state: reset low 1ms, outputs safe
// - Normal request: 150ms timeout, clear unwindowed
// - Normal: window watchdog, fail resets device
// - Stop/sleep: outputs off, wake on events
// - Low-power command must arrive twice
// - Config pin grounded disables, open gives 150ms
// - Period us equals 991 R plus 648
// - Mode bits: sleep, stop, clear, normal
// - Clear command reverts low mode bit
// - Interrupt on heat, switch trip, supply
// - D7 set means other bits show source
// - Wake from stop pulses interrupt low
// - Eight bits, MSB first, 15us spacing
// - Status captured at chip select fall
// - Write bit map and reset conditions
// - First read after reset shows battery loss
// - Slew select, termination removal in low power
// - Wake: pin change, bus, select rise
// - Fail: clear in closed window or none
// - Interrupt pulse low about 10us
`timescale 1ns/1ps
module sbcm_core #(
  parameter int TICK_CYC_P = sbcm_pkg::TICK_CYC,
  parameter int RESET_US   = sbcm_pkg::RESET_LOW_US,
  parameter int NREQ_US    = sbcm_pkg::NREQ_TOUT_US,
  parameter int WD_FIX_US  = sbcm_pkg::WD_FIXED_US
) (
  // Clock and reset
  input  wire logic                         clk_sys,
  input  wire logic                         rst,
  // Serial port
  input  wire logic                         sclk,
  input  wire logic                         csb_n,
  input  wire logic                         mosi,
  output logic                              miso,
  output logic                              miso_oe_n,
  // Switch control
  input  wire logic                         pwm_in,
  output logic [2:0]                        switch_out,
  // Wake pins
  input  wire logic                         wake_pin_a,
  input  wire logic                         wake_pin_b,
  // Analog monitors
  input  wire sbcm_pkg::sbcm_flt_t          flt_in,
  // Watchdog configuration
  input  wire logic                         wd_cfg_gnd,
  input  wire logic                         wd_cfg_open,
  input  wire logic [sbcm_pkg::RES_W-1:0]   wd_res_kohm,
  // Device outputs
  output logic                              int_n,
  output logic                              reset_n,
  output logic                              regulator_on,
  output logic                              amp_enable,
  output logic                              bus_recessive,
  output logic                              pullup_off,
  output logic [1:0]                        slew_mode
);
  import sbcm_pkg::*;

  localparam int PIN_W = 8 + FLT_W + RES_W;

  if (TICK_CYC_P < 1 || TICK_CYC_P >= 2**TICK_W) begin : g_bad_tick
    $error("Tick divider out of range");
  end
  if (RESET_US < 1 || NREQ_US < 1 || WD_FIX_US < 2 ||
      NREQ_US >= 2**US_W || WD_FIX_US >= 2**US_W ||
      RESET_US >= 2**US_W) begin : g_bad_time
    $error("Timer value does not fit the timer");
  end

  // Synchronised pins
  logic [PIN_W-1:0] pin_raw;
  logic [PIN_W-1:0] pin_s;
  logic             sclk_s;
  logic             csb_s;
  logic             cs_on_s;
  logic             mosi_s;
  logic             pwm_s;
  logic [1:0]       wk_s;
  logic             gnd_s;
  logic             open_s;
  logic [RES_W-1:0] res_s;
  sbcm_flt_t        flt_s;

  // Select enters inverted so the synchroniser resets to idle
  assign pin_raw = {sclk, ~csb_n, mosi, pwm_in, wake_pin_b, wake_pin_a,
                    wd_cfg_gnd, wd_cfg_open, flt_in, wd_res_kohm};

  sbcm_sync #(.W(PIN_W)) u_sync (
    .clk_sys (clk_sys),
    .rst     (rst),
    .din     (pin_raw),
    .dout    (pin_s)
  );

  assign {sclk_s, cs_on_s, mosi_s, pwm_s, wk_s, gnd_s, open_s} =
         pin_s[PIN_W-1 -: 8];
  assign csb_s = ~cs_on_s;
  assign flt_s = sbcm_flt_t'(pin_s[RES_W +: FLT_W]);
  assign res_s = pin_s[RES_W-1:0];

  // Microsecond tick
  logic [TICK_W-1:0] tick_cnt_reg;
  logic              tick_reg;

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      tick_cnt_reg <= '0;
      tick_reg     <= 1'b0;
    end else if (tick_cnt_reg == TICK_W'(TICK_CYC_P - 1)) begin
      tick_cnt_reg <= '0;
      tick_reg     <= 1'b1;
    end else begin
      tick_cnt_reg <= tick_cnt_reg + 1'b1;
      tick_reg     <= 1'b0;
    end
  end

  // Edge detection on synchronised levels
  logic       sclk_d_reg;
  logic       csb_d_reg;
  logic       sclk_rise;
  logic       sclk_fall;
  logic       cs_fall;
  logic       cs_rise;
  sbcm_flt_t  flt_d_reg;

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      sclk_d_reg <= 1'b0;
      csb_d_reg  <= 1'b1;
      flt_d_reg  <= '0;
    end else begin
      sclk_d_reg <= sclk_s;
      csb_d_reg  <= csb_s;
      flt_d_reg  <= flt_s;
    end
  end

  assign sclk_rise = sclk_s & ~sclk_d_reg;
  assign sclk_fall = ~sclk_s & sclk_d_reg;
  assign cs_fall   = ~csb_s & csb_d_reg;
  assign cs_rise   = csb_s & ~csb_d_reg;

  // State and control registers
  sbcm_state_t st_reg;
  sbcm_state_t st_next;
  sbcm_ctl_t   ctl_reg;
  sbcm_ctl_t   w;
  logic [7:0]  shift_reg;
  logic [3:0]  bit_cnt_reg;
  logic [7:0]  status_word;
  logic        wr_go;
  logic        active;
  logic        lowp;

  assign active = (st_reg == ST_NREQ) || (st_reg == ST_NORMAL);
  assign lowp   = (st_reg == ST_STOP) || (st_reg == ST_SLEEP);

  // Serial shifter, mode 0, MSB first
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      shift_reg   <= '0;
      bit_cnt_reg <= '0;
      miso        <= 1'b0;
      miso_oe_n   <= 1'b1;
    end else if (cs_fall) begin
      shift_reg   <= status_word;
      bit_cnt_reg <= '0;
      miso        <= status_word[7];
      miso_oe_n   <= 1'b0;
    end else if (cs_rise) begin
      miso_oe_n   <= 1'b1;
    end else if (!csb_s) begin
      if (sclk_rise) begin
        shift_reg <= {shift_reg[6:0], mosi_s};
        if (bit_cnt_reg <= 4'(SPI_BITS))
          bit_cnt_reg <= bit_cnt_reg + 1'b1;
      end else if (sclk_fall) begin
        miso <= shift_reg[7];
      end
    end
  end

  // Only an exact eight-clock frame counts as a write
  assign wr_go = cs_rise && (bit_cnt_reg == 4'(SPI_BITS)) && active;
  assign w     = sbcm_ctl_t'(shift_reg);

  // Control word storage
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      ctl_reg <= CTL_RST;
    end else if (st_reg == ST_RESET) begin
      ctl_reg.slew_sel_high <= 1'b0;
      ctl_reg.slew_sel_low  <= 1'b0;
      ctl_reg.switch_c_on   <= 1'b0;
      ctl_reg.switch_b_on   <= 1'b0;
      ctl_reg.switch_a_on   <= 1'b0;
      {ctl_reg.op_sel_high, ctl_reg.op_sel_low} <= OP_NORMAL;
    end else if (wr_go) begin
      ctl_reg.bus_termination_off <= w.bus_termination_off;
      ctl_reg.switch_c_on <= w.switch_c_on;
      ctl_reg.switch_b_on <= w.switch_b_on;
      ctl_reg.switch_a_on <= w.switch_a_on;
      if ({w.slew_sel_high, w.slew_sel_low} != SLEW_LOWPWR) begin
        ctl_reg.slew_sel_high <= w.slew_sel_high;
        ctl_reg.slew_sel_low  <= w.slew_sel_low;
      end
      if ({w.op_sel_high, w.op_sel_low} == OP_CLEAR)
        {ctl_reg.op_sel_high, ctl_reg.op_sel_low} <= OP_NORMAL;
      else
        {ctl_reg.op_sel_high, ctl_reg.op_sel_low} <=
          {w.op_sel_high, w.op_sel_low};
    end
  end

  // Low-power request must be sent twice in a row
  logic lp_arm_reg;
  logic lp_op_reg;
  logic lp_cmd;
  logic lp_enter;

  assign lp_cmd = ({w.slew_sel_high, w.slew_sel_low} == SLEW_LOWPWR) &&
                  !w.op_sel_high;
  assign lp_enter = wr_go && lp_cmd && lp_arm_reg &&
                    (lp_op_reg == w.op_sel_low) && (st_reg == ST_NORMAL);

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      lp_arm_reg <= 1'b0;
      lp_op_reg  <= 1'b0;
    end else if (!active) begin
      lp_arm_reg <= 1'b0;
    end else if (wr_go) begin
      lp_arm_reg <= lp_cmd && !lp_enter;
      lp_op_reg  <= w.op_sel_low;
    end
  end

  // Watchdog period from the configuration pin
  logic            wd_en;
  logic [US_W-1:0] wd_per;
  logic [US_W-1:0] tmr_reg;
  logic            clr_cmd;
  logic            tmr_clr;

  assign wd_en  = !gnd_s;
  assign wd_per = open_s ? US_W'(WD_FIX_US) :
                  US_W'(US_W'(WD_SLOPE_US) * US_W'(res_s)) +
                  US_W'(WD_OFFS_US);
  assign clr_cmd = wr_go && ({w.op_sel_high, w.op_sel_low} == OP_CLEAR);

  // Wake detection against levels frozen at low-power entry
  logic [1:0] wk_ref_reg;
  logic [1:0] wk_chg;
  logic       wake;

  assign wk_chg = lowp ? (wk_s ^ wk_ref_reg) : 2'h0;
  assign wake   = lowp && ((|wk_chg) || flt_s.bus_wake || cs_rise);

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst)
      wk_ref_reg <= 2'h0;
    else if (!lowp)
      wk_ref_reg <= wk_s;
  end

  // Mode machine
  always_comb begin
    st_next = st_reg;
    tmr_clr = 1'b0;
    case (st_reg)
      ST_RESET: begin
        if (tmr_reg >= US_W'(RESET_US))
          st_next = ST_NREQ;
      end
      ST_NREQ: begin
        if (flt_s.regulator_uv)
          st_next = ST_RESET;
        else if (wd_en && tmr_reg >= US_W'(NREQ_US))
          st_next = ST_RESET;
        else if (clr_cmd || (!wd_en && wr_go && w.op_sel_high))
          st_next = ST_NORMAL;
      end
      ST_NORMAL: begin
        if (flt_s.regulator_uv)
          st_next = ST_RESET;
        else if (wd_en && tmr_reg >= wd_per)
          st_next = ST_RESET;
        else if (wd_en && clr_cmd && tmr_reg < (wd_per >> 1))
          st_next = ST_RESET;
        else if (lp_enter)
          st_next = w.op_sel_low ? ST_STOP : ST_SLEEP;
        else if (clr_cmd)
          tmr_clr = 1'b1;
      end
      ST_STOP: begin
        if (flt_s.regulator_uv)
          st_next = ST_RESET;
        else if (wake)
          st_next = ST_NREQ;
      end
      ST_SLEEP: begin
        if (wake)
          st_next = ST_RESET;
      end
      default: st_next = ST_RESET;
    endcase
    if (st_next != st_reg)
      tmr_clr = 1'b1;
  end

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst)
      st_reg <= ST_RESET;
    else
      st_reg <= st_next;
  end

  // Shared state timer in microseconds, saturating
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst)
      tmr_reg <= '0;
    else if (tmr_clr)
      tmr_reg <= '0;
    else if (tick_reg && tmr_reg != '1)
      tmr_reg <= tmr_reg + 1'b1;
  end

  // Switch thermal latches
  logic [2:0] hot_lat_reg;
  logic [2:0] sw_bits;
  logic       ev_sw;

  assign sw_bits = {ctl_reg.switch_c_on, ctl_reg.switch_b_on,
                    ctl_reg.switch_a_on};
  assign ev_sw   = |(flt_s.switch_hot & ~hot_lat_reg);

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      hot_lat_reg <= 3'h0;
    end else begin
      for (int i = 0; i < 3; i++) begin
        if (flt_s.switch_hot[i])
          hot_lat_reg[i] <= 1'b1;
        else if (wr_go && shift_reg[ST_SW + i])
          hot_lat_reg[i] <= 1'b0;
      end
    end
  end

  // Supply latches: clear needs a read and the fault gone
  logic [1:0] sup_now;
  logic [1:0] sup_lat_reg;
  logic [1:0] sup_rd_reg;

  assign sup_now = {flt_s.supply_over, flt_s.supply_under};

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      sup_lat_reg <= 2'h0;
      sup_rd_reg  <= 2'h0;
    end else begin
      sup_lat_reg <= sup_now | (sup_lat_reg & ~(sup_rd_reg & ~sup_now));
      sup_rd_reg  <= sup_lat_reg & (sup_rd_reg | {2{cs_fall}});
    end
  end

  // Interrupt sources
  logic [6:0] ev_vec;
  logic [6:0] src_reg;
  logic       pend_reg;
  logic       first_rd_reg;
  logic       ev_int;
  logic       stop_wake;

  assign stop_wake = wake && (st_reg == ST_STOP);
  assign ev_vec[ST_BUS] = (flt_s.bus_fault & ~flt_d_reg.bus_fault) |
                          (wake & flt_s.bus_wake);
  assign ev_vec[ST_OV]  = flt_s.supply_over & ~flt_d_reg.supply_over;
  assign ev_vec[ST_UV]  = flt_s.supply_under & ~flt_d_reg.supply_under;
  assign ev_vec[ST_HOT] = flt_s.regulator_hot & ~flt_d_reg.regulator_hot;
  assign ev_vec[ST_SW]  = ev_sw;
  assign ev_vec[ST_WB]  = wake & wk_chg[1];
  assign ev_vec[ST_WA]  = wake & wk_chg[0];
  assign ev_int = |ev_vec[ST_OV:ST_SW];

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      src_reg  <= 7'h00;
      pend_reg <= 1'b0;
    end else begin
      src_reg  <= (cs_fall ? 7'h00 : src_reg) | ev_vec;
      pend_reg <= (cs_fall ? 1'b0 : pend_reg) | (|ev_vec);
    end
  end

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst)
      first_rd_reg <= 1'b1;
    else if (st_reg == ST_RESET)
      first_rd_reg <= 1'b1;
    else if (cs_fall)
      first_rd_reg <= 1'b0;
  end

  // Status word assembly
  always_comb begin
    status_word         = 8'h00;
    status_word[ST_SRC] = pend_reg;
    if (pend_reg) begin
      status_word[ST_BUS:ST_WA] = src_reg;
    end else begin
      status_word[ST_BUS] = flt_s.bus_fault | flt_s.bus_wake;
      status_word[ST_OV]  = sup_lat_reg[1];
      status_word[ST_UV]  = sup_lat_reg[0];
      status_word[ST_HOT] = flt_s.regulator_hot;
      status_word[ST_SW]  = |hot_lat_reg;
      status_word[ST_WB]  = wk_s[1];
      status_word[ST_WA]  = wk_s[0];
    end
    if (first_rd_reg)
      status_word[ST_UV] = flt_s.battery_lost;
  end

  // Interrupt pulse timer
  logic [3:0] int_cnt_reg;
  logic       int_go;

  assign int_go = (ev_int && active) || stop_wake;

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      int_cnt_reg <= 4'h0;
      int_n       <= 1'b1;
    end else if (int_go) begin
      int_cnt_reg <= 4'(INT_LOW_US);
      int_n       <= 1'b0;
    end else if (tick_reg && int_cnt_reg != 4'h0) begin
      int_cnt_reg <= int_cnt_reg - 1'b1;
      if (int_cnt_reg == 4'h1)
        int_n <= 1'b1;
    end
  end

  // Registered device outputs
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      reset_n       <= 1'b0;
      regulator_on  <= 1'b1;
      amp_enable    <= 1'b0;
      bus_recessive <= 1'b1;
      pullup_off    <= 1'b0;
      slew_mode     <= SLEW_NORMAL;
    end else begin
      reset_n       <= active || (st_reg == ST_STOP);
      regulator_on  <= st_reg != ST_SLEEP;
      amp_enable    <= st_reg == ST_NORMAL;
      bus_recessive <= !active;
      pullup_off    <= ctl_reg.bus_termination_off && lowp;
      slew_mode     <= {ctl_reg.slew_sel_high, ctl_reg.slew_sel_low};
    end
  end

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      switch_out <= 3'h0;
    end else begin
      switch_out[0] <= active && sw_bits[0] && !hot_lat_reg[0] && pwm_s;
      switch_out[1] <= active && sw_bits[1] && !hot_lat_reg[1] && pwm_s;
      switch_out[2] <= active && sw_bits[2] && !hot_lat_reg[2];
    end
  end

endmodule : sbcm_core

// file: src/sbcm_pkg.sv
// Shared constants and types for the mode, watchdog and serial control core.
// Assumes one 125 MHz system clock and timers that count microsecond ticks.
package sbcm_pkg;

  // Timing, in the unit given by the name
  localparam int CLK_MHZ      = 125;
  localparam int TICK_US      = 1;
  localparam int TICK_CYC     = CLK_MHZ * TICK_US;
  localparam int RESET_LOW_US = 1000;
  localparam int NREQ_TOUT_US = 150000;
  localparam int WD_FIXED_US  = 150000;
  localparam int WD_SLOPE_US  = 991;
  localparam int WD_OFFS_US   = 648;
  localparam int INT_LOW_US   = 10;

  // Widths
  localparam int US_W     = 20;
  localparam int TICK_W   = 16;
  localparam int RES_W    = 8;
  localparam int SPI_BITS = 8;

  // Status word bit positions
  localparam int ST_SRC = 7;
  localparam int ST_BUS = 6;
  localparam int ST_OV  = 5;
  localparam int ST_UV  = 4;
  localparam int ST_HOT = 3;
  localparam int ST_SW  = 2;
  localparam int ST_WB  = 1;
  localparam int ST_WA  = 0;

  // Mode field and slew field codes
  localparam logic [1:0] OP_SLEEP    = 2'h0;
  localparam logic [1:0] OP_STOP     = 2'h1;
  localparam logic [1:0] OP_CLEAR    = 2'h2;
  localparam logic [1:0] OP_NORMAL   = 2'h3;
  localparam logic [1:0] SLEW_LOWPWR = 2'h3;
  localparam logic [1:0] SLEW_NORMAL = 2'h0;

  typedef struct packed {
    logic slew_sel_high;
    logic slew_sel_low;
    logic bus_termination_off;
    logic switch_c_on;
    logic switch_b_on;
    logic switch_a_on;
    logic op_sel_high;
    logic op_sel_low;
  } sbcm_ctl_t;

  localparam sbcm_ctl_t CTL_RST = 8'h03;

  typedef struct packed {
    logic       supply_over;
    logic       supply_under;
    logic       battery_lost;
    logic       regulator_hot;
    logic       regulator_uv;
    logic       bus_fault;
    logic       bus_wake;
    logic [2:0] switch_hot;
  } sbcm_flt_t;

  localparam int FLT_W = $bits(sbcm_flt_t);

  typedef enum logic [2:0] {
    ST_RESET  = 3'h0,
    ST_NREQ   = 3'h1,
    ST_NORMAL = 3'h3,
    ST_STOP   = 3'h2,
    ST_SLEEP  = 3'h6
  } sbcm_state_t;

endpackage : sbcm_pkg

// file: src/sbcm_sync.sv
// Two-stage synchroniser for a vector of asynchronous pin levels.
// Assumes the bits are independent levels; no multi-bit coherence.
`timescale 1ns/1ps
module sbcm_sync #(
  parameter int W = 1
) (
  // Clock and reset
  input  wire logic         clk_sys,
  input  wire logic         rst,
  // Levels
  input  wire logic [W-1:0] din,
  output logic      [W-1:0] dout
);
  logic [W-1:0] meta_reg;

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      meta_reg <= '0;
      dout     <= '0;
    end else begin
      meta_reg <= din;
      dout     <= meta_reg;
    end
  end
endmodule : sbcm_sync

// file: tb/sbcm_host.sv
// Serial master model standing in for the host controller.
// Assumes mode 0 frames and a free-standing 125 ns serial clock.
`timescale 1ns/1ps
module sbcm_host (
  // Serial pins
  output logic      sclk,
  output logic      csb_n,
  output logic      mosi,
  input  wire logic miso
);
  initial begin
    sclk  = 1'b0;
    csb_n = 1'b1;
    mosi  = 1'b0;
  end

  task automatic xfer(input logic [7:0] w, output logic [7:0] r);
    csb_n = 1'b0;
    for (int i = 7; i >= 0; i--) begin
      mosi = w[i];
      #62.5 sclk = 1'b1;
      r[i] = miso;
      #62.5 sclk = 1'b0;
    end
    #62.5 csb_n = 1'b1;
    mosi = ~w[0];
    #15000;
  endtask : xfer
endmodule : sbcm_host

// file: tb/sbcm_props.sv
// Port checker for the control core, bound to its top module.
// Assumes one tick per clk_sys cycle in simulation.
`timescale 1ns/1ps
module sbcm_props (
  // Clock and reset
  input wire logic                clk_sys,
  input wire logic                rst,
  // Inputs watched
  input wire logic                csb_n,
  input wire logic                pwm_in,
  input wire sbcm_pkg::sbcm_flt_t flt_in,
  // Outputs watched
  input wire logic                miso_oe_n,
  input wire logic [2:0]          switch_out,
  input wire logic                int_n,
  input wire logic                reset_n,
  input wire logic                regulator_on,
  input wire logic                amp_enable,
  input wire logic                bus_recessive,
  input wire logic                pullup_off,
  input wire logic [1:0]          slew_mode
);
  import sbcm_pkg::*;
  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (rst);

  AST_SW_GATE:
    assert property (!pwm_in [*5] |=> switch_out[1:0] == 2'h0)
    else $error("switch on with gate low");
  AST_TRIP_OFF:
    assert property (flt_in.switch_hot[0] [*5] |=> !switch_out[0])
    else $error("hot switch still on");
  AST_RESET_SAFE:
    assert property (!reset_n [*2] |-> switch_out == 3'h0 && bus_recessive
      && !amp_enable)
    else $error("outputs active in reset");
  AST_RESET_LEN:
    assert property ($fell(reset_n) |-> !reset_n [*8])
    else $error("reset pulse too short");
  AST_INT_PULSE:
    assert property ($fell(int_n) |-> !int_n [*8] ##[1:20] int_n)
    else $error("interrupt pulse length wrong");
  AST_LOWPWR_OFF:
    assert property (!regulator_on [*2] |-> !reset_n && switch_out == 3'h0
      && bus_recessive)
    else $error("outputs active in sleep");
  AST_NORMAL_ENTRY:
    assert property ($rose(amp_enable) |-> reset_n && !bus_recessive
      && regulator_on)
    else $error("normal entered in wrong state");
  AST_MISO_DRIVE:
    assert property ($fell(csb_n) && amp_enable |-> ##[2:6] !miso_oe_n)
    else $error("data out not driven");
  AST_MISO_IDLE:
    assert property (csb_n [*6] |-> miso_oe_n)
    else $error("data out driven while idle");
  AST_PULLUP_ACTIVE:
    assert property (!bus_recessive [*3] |-> !pullup_off)
    else $error("pull-up removed in active mode");
  AST_SLEW_CODE:
    assert property (slew_mode != 2'h3)
    else $error("slew code reserved");

  cover property ($fell(int_n));
  cover property ($rose(amp_enable));
  cover property ($fell(regulator_on));
endmodule : sbcm_props

bind sbcm_core sbcm_props u_props (
  .clk_sys, .rst, .csb_n, .pwm_in, .flt_in, .miso_oe_n, .switch_out,
  .int_n, .reset_n, .regulator_on, .amp_enable, .bus_recessive,
  .pullup_off, .slew_mode
);

// file: tb/test_sbc_mode_spi_control.sv
// Self-checking bench for the mode, watchdog and serial control core.
// Assumes the host model for frames and shortened timers.
`timescale 1ns/1ps
module test_sbc_mode_spi_control;
  import sbcm_pkg::*;
  logic       clk_sys, rst, sclk, csb_n, mosi, miso, miso_oe_n, pwm_in;
  logic       wake_pin_a, wake_pin_b, wd_cfg_gnd, wd_cfg_open, int_n;
  logic       reset_n, regulator_on, amp_enable, bus_recessive, pullup_off;
  logic [2:0] switch_out;
  logic [1:0] slew_mode;
  logic [7:0] rd, wd_res_kohm;
  sbcm_flt_t  flt_in;
  int         bad_count, cmp_count, cyc, k;

  sbcm_core #(
    .TICK_CYC_P(1), .RESET_US(20), .NREQ_US(5000), .WD_FIX_US(8000)
  ) u_dut (
    .clk_sys, .rst, .sclk, .csb_n, .mosi, .miso, .miso_oe_n, .pwm_in,
    .switch_out, .wake_pin_a, .wake_pin_b, .flt_in, .wd_cfg_gnd,
    .wd_cfg_open, .wd_res_kohm, .int_n, .reset_n, .regulator_on,
    .amp_enable, .bus_recessive, .pullup_off, .slew_mode
  );
  sbcm_host u_host (.sclk, .csb_n, .mosi, .miso);

  always #4 clk_sys = ~clk_sys;

  always @(posedge clk_sys) begin
    cyc <= cyc + 1;
    if (cyc == 90000) begin
      bad_count++;
      complete_run();
    end
  end

  task complete_run();
    $display("checks %0d mismatches %0d", cmp_count, bad_count);
    if (bad_count == 0 && cmp_count > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask : complete_run

  task chk(input string n, input logic [7:0] s, input logic [7:0] e);
    cmp_count++;
    if (s !== e) begin
      bad_count++;
      $display("BAD %s expected %h seen %h", n, e, s);
    end
  endtask : chk

  task wint();
    k = 0;
    while (int_n !== 1'b0 && k < 3000) begin
      @(negedge clk_sys);
      k++;
    end
    chk("int_n", 8'(int_n), 8'h00);
  endtask : wint

  task wait_rst(input logic v);
    k = 0;
    while (reset_n !== v && k < 9000) begin
      @(negedge clk_sys);
      k++;
    end
  endtask : wait_rst

  task t_start();
    repeat (2) @(negedge clk_sys);
    chk("rst_out", 8'({reset_n, switch_out, bus_recessive}), 8'h01);
    wait_rst(1'b1);
    chk("rst_len", 8'(k > 15 && k < 30), 8'h01);
    u_host.xfer(8'h1f, rd);
    chk("batt", rd & 8'h10, 8'h10);
    chk("normal", 8'({amp_enable, switch_out}), 8'h0f);
  endtask : t_start

  task t_pwm();
    logic [7:0] cmd [4];
    logic [1:0] exp [4];
    cmd = '{8'h5f, 8'h9f, 8'hdf, 8'h1f};
    exp = '{2'h1, 2'h2, 2'h2, 2'h0};
    @(posedge clk_sys);
    pwm_in <= 1'b0;
    flt_in.battery_lost <= 1'b0;
    repeat (8) @(negedge clk_sys);
    chk("pwm_lo", 8'(switch_out), 8'h04);
    @(posedge clk_sys);
    pwm_in <= 1'b1;
    for (int i = 0; i < 4; i++) begin
      u_host.xfer(cmd[i], rd);
      chk("slew", 8'(slew_mode), 8'(exp[i]));
    end
  endtask : t_pwm

  task t_trip();
    @(posedge clk_sys);
    flt_in.switch_hot[0] <= 1'b1;
    wint();
    repeat (8) @(posedge clk_sys);
    flt_in.switch_hot[0] <= 1'b0;
    repeat (50) @(negedge clk_sys);
    chk("held", 8'(switch_out), 8'h06);
    u_host.xfer(8'h1f, rd);
    chk("src", rd, 8'h84);
    u_host.xfer(8'h1f, rd);
    chk("live", rd, 8'h00);
    chk("rearm", 8'(switch_out), 8'h07);
  endtask : t_trip

  task t_supply();
    for (int i = 0; i < 3; i++) begin
      @(posedge clk_sys);
      flt_in.supply_over <= (i == 0);
      flt_in.supply_under <= (i == 1);
      flt_in.regulator_hot <= (i == 2);
      wint();
      @(posedge clk_sys);
      flt_in.supply_over <= 1'b0;
      flt_in.supply_under <= 1'b0;
      flt_in.regulator_hot <= 1'b0;
      repeat (50) @(negedge clk_sys);
      u_host.xfer(8'h1f, rd);
      chk("sup_src", rd,
          (i == 0) ? 8'ha0 : (i == 1) ? 8'h90 : 8'h88);
      u_host.xfer(8'h1f, rd);
      chk("sup_clr", rd, 8'h00);
    end
  endtask : t_supply

  task t_stop();
    u_host.xfer(8'he1, rd);
    chk("armed", 8'(amp_enable), 8'h01);
    u_host.xfer(8'he1, rd);
    chk("stop", 8'({amp_enable, bus_recessive, pullup_off, switch_out}),
        8'h18);
    @(posedge clk_sys);
    wake_pin_b <= 1'b1;
    wint();
    @(posedge clk_sys);
    wake_pin_b <= 1'b0;
    repeat (50) @(negedge clk_sys);
    u_host.xfer(8'h1f, rd);
    chk("wake_src", rd & 8'h03, 8'h02);
    u_host.xfer(8'h1f, rd);
    chk("wake_live", rd & 8'h03, 8'h00);
  endtask : t_stop

  task t_sleep();
    u_host.xfer(8'he0, rd);
    u_host.xfer(8'he0, rd);
    chk("sleep", 8'({regulator_on, reset_n, switch_out}), 8'h00);
    u_host.xfer(8'h1f, rd);
    chk("woke", 8'({regulator_on, reset_n, amp_enable}), 8'h06);
    u_host.xfer(8'h1f, rd);
    @(posedge clk_sys);
    flt_in.regulator_uv <= 1'b1;
    wait_rst(1'b0);
    chk("uv_rst", 8'({amp_enable, k < 8}), 8'h01);
    @(posedge clk_sys);
    flt_in.regulator_uv <= 1'b0;
  endtask : t_sleep

  task t_wdog();
    @(posedge clk_sys);
    rst <= 1'b1;
    wd_cfg_gnd <= 1'b0;
    wd_cfg_open <= 1'b1;
    repeat (20) @(posedge clk_sys);
    rst <= 1'b0;
    wait_rst(1'b1);
    wait_rst(1'b0);
    chk("nreq_tout", 8'(k > 4980 && k < 5020), 8'h01);
    wait_rst(1'b1);
    u_host.xfer(8'h1e, rd);
    chk("wd_clr", 8'(amp_enable), 8'h01);
    u_host.xfer(8'h1e, rd);
    chk("wd_early", 8'(amp_enable), 8'h00);
  endtask : t_wdog

  // Resistor of 2 kohm: period 991 * 2 + 648 = 2630 ticks
  task t_wres();
    @(posedge clk_sys);
    rst <= 1'b1;
    wd_cfg_open <= 1'b0;
    wd_res_kohm <= 8'h02;
    repeat (20) @(posedge clk_sys);
    rst <= 1'b0;
    wait_rst(1'b1);
    for (int i = 0; i < 2; i++) begin
      u_host.xfer(8'h1e, rd);
      chk("wd_open", 8'(amp_enable), 8'h01);
    end
    wait_rst(1'b0);
    chk("wd_res", 8'(k > 740 && k < 780), 8'h01);
  endtask : t_wres

  initial begin
    clk_sys = 1'b0;
    rst = 1'b1;
    pwm_in = 1'b1;
    flt_in = '0;
    flt_in.battery_lost = 1'b1;
    wake_pin_a = 1'b0;
    wake_pin_b = 1'b0;
    wd_cfg_gnd = 1'b1;
    wd_cfg_open = 1'b0;
    wd_res_kohm = 8'h00;
    bad_count = 0;
    cmp_count = 0;
    cyc = 0;
    repeat (20) @(posedge clk_sys);
    rst <= 1'b0;
    t_start();
    t_pwm();
    t_trip();
    t_supply();
    t_stop();
    t_sleep();
    t_wdog();
    t_wres();
    complete_run();
  end
endmodule : test_sbc_mode_spi_control
